// ==== core/pkw_pkg.sv ====
// shared constants for the port, external interrupt and keypad wake block
package pkw_pkg;
  // geometry
  localparam int PORT_W = 8;
  localparam int NPORT = 3;
  localparam int NPIN = 24;
  // per-pin output modes, bit a then bit b
  localparam logic [1:0] MODE_QUASI = 2'h0;
  localparam logic [1:0] MODE_PUSH = 2'h1;
  localparam logic [1:0] MODE_INPUT = 2'h2;
  localparam logic [1:0] MODE_OPEN = 2'h3;
  // timing, in cpu clocks
  localparam int MC_CLKS = 6;
  localparam int STRONG_PU_CLKS = 2;
  localparam int MC_CNT_W = 3;
  localparam logic [MC_CNT_W-1:0] MC_LAST = MC_CNT_W'(MC_CLKS - 1);
  localparam logic [1:0] STRONG_PU_CNT = 2'(STRONG_PU_CLKS);
  // fixed-function pins, flat index = port*8 + bit
  localparam int PIN_OD_A = 10;
  localparam int PIN_OD_B = 11;
  localparam int PIN_RST = 13;
  localparam int PIN_X2 = 16;
  localparam int PIN_X1 = 17;
  localparam int P2_PINS = 2;
  // register offsets
  localparam logic [3:0] ADDR_P0_LATCH = 4'h0;
  localparam logic [3:0] ADDR_P1_LATCH = 4'h1;
  localparam logic [3:0] ADDR_P2_LATCH = 4'h2;
  localparam logic [3:0] ADDR_P0_MODE_A = 4'h3;
  localparam logic [3:0] ADDR_P0_MODE_B = 4'h4;
  localparam logic [3:0] ADDR_P1_MODE_A = 4'h5;
  localparam logic [3:0] ADDR_P1_MODE_B = 4'h6;
  localparam logic [3:0] ADDR_P2_MODE_A = 4'h7;
  localparam logic [3:0] ADDR_P2_MODE_B = 4'h8;
  localparam logic [3:0] ADDR_TIRQ_CTRL = 4'h9;
  localparam logic [3:0] ADDR_KEYPAD_EN = 4'hA;
  localparam logic [3:0] ADDR_AUX_CTRL = 4'hB;
  localparam logic [3:0] ADDR_IRQ_EN = 4'hC;
  localparam logic [3:0] ADDR_P0_PINS = 4'hD;
  localparam logic [3:0] ADDR_P1_PINS = 4'hE;
  localparam logic [3:0] ADDR_P2_PINS = 4'hF;
  // port2 mode-a register fields above the two mode bits
  localparam int P2A_SCHMITT0 = 2;
  localparam int P2A_TOG0 = 5;
  localparam int P2A_TOG1 = 6;
  localparam int P2A_CLKOUT = 7;
  // timer/irq control fields
  localparam int TIRQ_EDGE0 = 0;
  localparam int TIRQ_FLAG0 = 1;
  localparam int TIRQ_EDGE1 = 2;
  localparam int TIRQ_FLAG1 = 3;
  // auxiliary and enable fields
  localparam int AUX_KB_FLAG = 0;
  localparam int IEN_EXT0 = 0;
  localparam int IEN_EXT1 = 1;
  localparam int IEN_KB = 2;
  // reset values
  localparam logic [NPIN-1:0] MODE_RESET = 24'h000000;
  localparam logic [5:0] P2CFG_RESET = 6'h00;
endpackage : pkw_pkg

// ==== core/pkw_port_io.sv ====
// port pin drivers, external interrupt sensing and keypad wake logic
`timescale 1ns/1ps
// Functional notes
// RULE1 - edge select clear: low level requests interrupt
// RULE2 - edge select set: high then low sample
// RULE3 - source holds each level six cpu clocks
// RULE4 - edge mode: high one cycle, low one
// RULE5 - edge flag clears when interrupt is vectored
// RULE6 - level flag tracks pin, reasserts if low
// RULE7 - enabled external interrupt wakes idle/power down
// RULE8 - two mode bits pick output type
// RULE9 - quasi-bidirectional is the reset mode
// RULE10 - quasi: very weak pull-up when latch one
// RULE11 - quasi: weak pull-up when latch, pin one
// RULE12 - quasi: strong pull-up two clocks on rise
// RULE13 - open drain: no pull-ups, pull-down on zero
// RULE14 - push-pull: strong pull-up while latch one
// RULE15 - fixed open-drain pins, reset pin input
// RULE16 - crystal option disables two port2 pins
// RULE17 - reset level from nonvolatile bit, quasi mode
// RULE18 - per-port schmitt select, fixed pins always
// RULE19 - spare port2 mode bits hold extra enables
// RULE20 - enabled port0 pin low sets keypad flag
// RULE21 - keypad flag software cleared, gated request
// RULE22 - keypad interrupt wakes idle/power down
// RULE23 - input only: all drivers off, readable
module pkw_port_io
  import pkw_pkg::*;
#(
  parameter int PIN_COUNT = NPIN
)(
  input wire logic clk, // cpu clock
  input wire logic reset_n, // synchronous reset
  input wire logic [3:0] reg_addr, // register address
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_we, // write strobe
  input wire logic reg_re, // read strobe
  output logic [7:0] reg_rdata, // read data, cycle after strobe
  input wire logic [NPIN-1:0] pin_in, // pin levels, port*8+bit
  output logic [NPIN-1:0] pin_pull_down, // pull-down on
  output logic [NPIN-1:0] pin_pu_very_weak, // very weak pull-up on
  output logic [NPIN-1:0] pin_pu_weak, // weak pull-up on
  output logic [NPIN-1:0] pin_pu_strong, // strong pull-up on
  output logic [NPIN-1:0] pin_in_en, // input buffer on
  output logic [NPIN-1:0] pin_schmitt, // schmitt input selected
  input wire logic [1:0] ext_irq_pin_n, // external interrupt pins
  input wire logic [1:0] ext_irq_vector, // cpu vectors to ext irq
  input wire logic port_reset_high_cfg, // nonvolatile reset level
  input wire logic crystal_osc_sel, // crystal oscillator option
  input wire logic internal_reset_cfg, // internal reset option
  input wire logic cpu_idle, // cpu in idle
  input wire logic cpu_power_down, // cpu in power down
  output logic [1:0] ext_irq_request, // external interrupt requests
  output logic keypad_irq_request, // keypad interrupt request
  output logic cpu_wake, // wake from idle or power down
  output logic [1:0] timer_toggle_en, // timer toggle output enables
  output logic clock_out_en // clock output enable
);

  if (PIN_COUNT != NPIN)
  begin : g_bad_pins
    $error("pkw_port_io supports exactly 24 pin positions");
  end

  typedef struct packed {
    logic [NPIN-1:0] latch;
    logic [NPIN-1:0] mode_a;
    logic [NPIN-1:0] mode_b;
    logic [5:0] p2cfg;
    logic [1:0] edge_sel;
    logic [1:0] req;
    logic [1:0] last_smp;
    logic [MC_CNT_W-1:0] mc_cnt;
    logic [NPIN-1:0][1:0] sp_cnt;
    logic [7:0] kb_mask;
    logic kb_flag;
    logic [2:0] irq_en;
    logic [7:0] rdata;
  } pkw_state_type;

  pkw_state_type st_q;
  pkw_state_type st_d;
  logic [NPIN-1:0] pin_seen;
  logic [7:0] wide_tirq;
  logic kb_hit;
  logic mc_tick;

  // pin read value: disabled inputs read as zero
  assign pin_seen = pin_in & pin_in_en;
  assign mc_tick = (st_q.mc_cnt == MC_LAST);
  // keypad active only while some pin is enabled
  assign kb_hit = |(st_q.kb_mask & ~pin_seen[PORT_W-1:0]); // RULE20
  assign wide_tirq = {4'h0, st_q.req[1], st_q.edge_sel[1], st_q.req[0], st_q.edge_sel[0]};

  for (genvar i = 0; i < NPIN; i++)
  begin : g_pin
    logic [1:0] mode;
    logic absent;
    logic disabled;
    logic quasi;
    logic lat;
    // pins above the two port2 pins do not exist
    assign absent = (i >= 2 * PORT_W + P2_PINS);
    assign disabled = absent || (crystal_osc_sel && (i == PIN_X1 || i == PIN_X2)); // RULE16
    assign lat = st_q.latch[i];
    always_comb
    begin
      if (i == PIN_OD_A || i == PIN_OD_B)
        mode = MODE_OPEN; // RULE15
      else if (i == PIN_RST)
        mode = MODE_INPUT; // RULE15
      else
        mode = {st_q.mode_a[i], st_q.mode_b[i]}; // RULE8
    end
    assign quasi = (mode == MODE_QUASI) && !disabled;
    // input and open drain never drive high
    assign pin_pu_very_weak[i] = quasi && lat; // RULE10
    assign pin_pu_weak[i] = quasi && lat && pin_in[i]; // RULE11
    // latch gate stops the strong pulse fighting a fresh pull-down
    assign pin_pu_strong[i] = !disabled && ((quasi && lat && st_q.sp_cnt[i] != 2'h0) // RULE12
      || (mode == MODE_PUSH && lat)); // RULE14
    assign pin_pull_down[i] = !disabled && mode != MODE_INPUT && !lat; // RULE13 RULE23
    assign pin_in_en[i] = !disabled && (i != PIN_RST || internal_reset_cfg); // RULE15 RULE23
    assign pin_schmitt[i] = (i == PIN_OD_A || i == PIN_OD_B || i == PIN_RST) // RULE18
      || st_q.p2cfg[P2A_SCHMITT0 - 2 + i / PORT_W];
  end

  always_comb
  begin
    logic [1:0] smp;
    logic [1:0] edge_set;
    logic [NPIN-1:0] new_latch;
    smp = ext_irq_pin_n;
    edge_set = 2'h0;
    new_latch = st_q.latch;
    st_d = st_q;
    st_d.mc_cnt = mc_tick ? '0 : st_q.mc_cnt + MC_CNT_W'(1);
    // strong pull-up countdown
    for (int i = 0; i < NPIN; i++)
    begin
      if (st_q.sp_cnt[i] != 2'h0)
        st_d.sp_cnt[i] = st_q.sp_cnt[i] - 2'h1;
    end
    // register writes
    if (reg_we)
    begin
      case (reg_addr)
        ADDR_P0_LATCH: new_latch[7:0] = reg_wdata;
        ADDR_P1_LATCH: new_latch[15:8] = reg_wdata;
        ADDR_P2_LATCH: new_latch[23:16] = reg_wdata;
        ADDR_P0_MODE_A: st_d.mode_a[7:0] = reg_wdata;
        ADDR_P0_MODE_B: st_d.mode_b[7:0] = reg_wdata;
        ADDR_P1_MODE_A: st_d.mode_a[15:8] = reg_wdata;
        ADDR_P1_MODE_B: st_d.mode_b[15:8] = reg_wdata;
        ADDR_P2_MODE_A:
        begin
          st_d.mode_a[17:16] = reg_wdata[1:0];
          st_d.p2cfg = reg_wdata[7:2]; // RULE19
        end
        ADDR_P2_MODE_B: st_d.mode_b[17:16] = reg_wdata[1:0];
        ADDR_TIRQ_CTRL:
        begin
          st_d.edge_sel[0] = reg_wdata[TIRQ_EDGE0];
          st_d.edge_sel[1] = reg_wdata[TIRQ_EDGE1];
          st_d.req[0] = reg_wdata[TIRQ_FLAG0];
          st_d.req[1] = reg_wdata[TIRQ_FLAG1];
        end
        ADDR_KEYPAD_EN: st_d.kb_mask = reg_wdata;
        ADDR_AUX_CTRL: st_d.kb_flag = reg_wdata[AUX_KB_FLAG]; // RULE21
        ADDR_IRQ_EN: st_d.irq_en = reg_wdata[2:0];
        default: st_d.irq_en = st_q.irq_en;
      endcase
    end
    // a 0 to 1 latch change arms the strong pull-up
    for (int i = 0; i < NPIN; i++)
    begin
      if (new_latch[i] && !st_q.latch[i])
        st_d.sp_cnt[i] = STRONG_PU_CNT; // RULE12
    end
    st_d.latch = new_latch;
    // edge flags: vector clears, a fresh edge beats any clear
    for (int n = 0; n < 2; n++)
    begin
      if (st_q.edge_sel[n] && ext_irq_vector[n])
        st_d.req[n] = 1'b0; // RULE5
      if (mc_tick)
      begin
        st_d.last_smp[n] = smp[n];
        // one sample per machine cycle; source must hold six clocks
        if (st_q.edge_sel[n])
          edge_set[n] = st_q.last_smp[n] && !smp[n]; // RULE2 RULE3 RULE4
        else
          st_d.req[n] = !smp[n]; // RULE1 RULE6
      end
      if (edge_set[n])
        st_d.req[n] = 1'b1; // RULE2
    end
    // level mode flag follows the sampled pin, software writes ignored
    for (int n = 0; n < 2; n++)
    begin
      if (!st_q.edge_sel[n] && !mc_tick && reg_we && reg_addr == ADDR_TIRQ_CTRL)
        st_d.req[n] = st_q.req[n]; // RULE6
    end
    // set beats software clear
    if (kb_hit)
      st_d.kb_flag = 1'b1; // RULE20 RULE21
    // read data, one cycle after the strobe
    st_d.rdata = 8'h00;
    if (reg_re)
    begin
      case (reg_addr)
        ADDR_P0_LATCH: st_d.rdata = st_q.latch[7:0];
        ADDR_P1_LATCH: st_d.rdata = st_q.latch[15:8];
        ADDR_P2_LATCH: st_d.rdata = st_q.latch[23:16];
        ADDR_P0_MODE_A: st_d.rdata = st_q.mode_a[7:0];
        ADDR_P0_MODE_B: st_d.rdata = st_q.mode_b[7:0];
        ADDR_P1_MODE_A: st_d.rdata = st_q.mode_a[15:8];
        ADDR_P1_MODE_B: st_d.rdata = st_q.mode_b[15:8];
        ADDR_P2_MODE_A: st_d.rdata = {st_q.p2cfg, st_q.mode_a[17:16]};
        ADDR_P2_MODE_B: st_d.rdata = {6'h00, st_q.mode_b[17:16]};
        ADDR_TIRQ_CTRL: st_d.rdata = wide_tirq;
        ADDR_KEYPAD_EN: st_d.rdata = st_q.kb_mask;
        ADDR_AUX_CTRL: st_d.rdata = {7'h00, st_q.kb_flag};
        ADDR_IRQ_EN: st_d.rdata = {5'h00, st_q.irq_en};
        ADDR_P0_PINS: st_d.rdata = pin_seen[7:0];
        ADDR_P1_PINS: st_d.rdata = pin_seen[15:8];
        ADDR_P2_PINS: st_d.rdata = pin_seen[23:16];
        default: st_d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      st_q <= '0;
      // reset level strap, caught while reset is held
      st_q.latch <= {NPIN{port_reset_high_cfg}}; // RULE17
      st_q.mode_a <= MODE_RESET; // RULE9 RULE17
      st_q.mode_b <= MODE_RESET; // RULE9
      st_q.p2cfg <= P2CFG_RESET;
      st_q.last_smp <= 2'h3;
    end
    else
      st_q <= st_d;
  end

  assign reg_rdata = st_q.rdata;
  assign ext_irq_request[0] = st_q.req[0] && st_q.irq_en[IEN_EXT0];
  assign ext_irq_request[1] = st_q.req[1] && st_q.irq_en[IEN_EXT1];
  assign keypad_irq_request = st_q.kb_flag && st_q.irq_en[IEN_KB]; // RULE21
  // any enabled request wakes a sleeping cpu
  assign cpu_wake = (cpu_idle || cpu_power_down)
    && (|ext_irq_request || keypad_irq_request); // RULE7 RULE22
  assign timer_toggle_en = {st_q.p2cfg[P2A_TOG1 - 2], st_q.p2cfg[P2A_TOG0 - 2]}; // RULE19
  assign clock_out_en = st_q.p2cfg[P2A_CLKOUT - 2]; // RULE19

endmodule : pkw_port_io

// ==== tb/pkw_port_io_assertions.sv ====
// concurrent checks on the port block pins and requests
`timescale 1ns/1ps
module pkw_port_io_chk
  import pkw_pkg::*;
(
  input wire logic clk, // clock
  input wire logic reset_n, // reset
  input wire logic reg_we, // write
  input wire logic [NPIN-1:0] pin_in, // levels
  input wire logic [NPIN-1:0] pin_pull_down, // pd
  input wire logic [NPIN-1:0] pin_pu_very_weak, // vw
  input wire logic [NPIN-1:0] pin_pu_weak, // weak
  input wire logic [NPIN-1:0] pin_pu_strong, // strong
  input wire logic [NPIN-1:0] pin_in_en, // in en
  input wire logic [1:0] ext_irq_pin_n, // irq pins
  input wire logic [1:0] ext_irq_vector, // vector
  input wire logic crystal_osc_sel, // crystal
  input wire logic cpu_idle, // idle
  input wire logic cpu_power_down, // pd mode
  input wire logic [1:0] ext_irq_request, // ext req
  input wire logic keypad_irq_request, // kb req
  input wire logic cpu_wake // wake
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  weak_pu_gate_a: assert property ((pin_pu_weak & ~(pin_pu_very_weak & pin_in)) == '0)
    else $error("weak pull-up on without latch and pin high");
  drive_clash_a: assert property
    ((pin_pull_down & (pin_pu_very_weak | pin_pu_weak | pin_pu_strong)) == '0)
    else $error("pull-down and pull-up on together");
  fixed_od_a: assert property
    (((pin_pu_very_weak | pin_pu_weak | pin_pu_strong) & 24'h000C00) == '0)
    else $error("pull-up on a fixed open-drain pin");
  crystal_off_a: assert property (crystal_osc_sel |->
    ((pin_in_en | pin_pull_down | pin_pu_very_weak | pin_pu_strong) & 24'h030000) == '0)
    else $error("oscillator pins not disabled");
  ext_rise_a: assert property
    ($rose(ext_irq_request[0]) |-> $past(reg_we || !ext_irq_pin_n[0]))
    else $error("ext request rose without low pin");
  ext_fall_a: assert property
    ($fell(ext_irq_request[0]) |-> $past(reg_we || ext_irq_vector[0] || ext_irq_pin_n[0]))
    else $error("ext request fell without cause");
  kb_hold_a: assert property ($fell(keypad_irq_request) |-> $past(reg_we))
    else $error("keypad request dropped without write");
  kb_set_a: assert property
    ($rose(keypad_irq_request) |-> $past(reg_we || pin_in[7:0] != 8'hFF))
    else $error("keypad request rose with port high");
  wake_a: assert property (cpu_wake == ((cpu_idle || cpu_power_down) &&
    (|ext_irq_request || keypad_irq_request)))
    else $error("wake does not match requests");
endmodule : pkw_port_io_chk

bind pkw_port_io pkw_port_io_chk i_chk (.clk, .reset_n, .reg_we, .pin_in, .pin_pull_down,
  .pin_pu_very_weak, .pin_pu_weak, .pin_pu_strong, .pin_in_en, .ext_irq_pin_n,
  .ext_irq_vector, .crystal_osc_sel, .cpu_idle, .cpu_power_down, .ext_irq_request,
  .keypad_irq_request, .cpu_wake);

// ==== tb/pkw_pin_model.sv ====
// external keys, pin loads and interrupt sources
`timescale 1ns/1ps
module pkw_pin_model
  import pkw_pkg::*;
(
  input wire logic clk, // clock
  input wire logic [NPIN-1:0] key_low, // keys closed
  input wire logic [1:0] irq_low, // sources active
  input wire logic [NPIN-1:0] pd, // pull-downs
  input wire logic [NPIN-1:0] pu, // very weak or strong
  output logic [NPIN-1:0] pin_in, // wire levels
  output logic [1:0] ext_irq_pin_n // irq lines
);
  logic [NPIN-1:0] flt_q = '0;
  always @(posedge clk) flt_q <= ~flt_q;
  // undriven pins toggle; weak pull-up left out to avoid a loop
  assign pin_in = ~(pd | key_low) & (pu | flt_q);
  // caller holds each level twelve clocks
  assign ext_irq_pin_n = ~irq_low;
endmodule : pkw_pin_model

// ==== tb/tb.sv ====
// self-checking bench for the port, interrupt and keypad block
`timescale 1ns/1ps
module tb
  import pkw_pkg::*;
;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic [7:0] reg_rdata;
  logic [NPIN-1:0] pin_in, pin_pull_down, pin_pu_very_weak, pin_pu_weak;
  logic [NPIN-1:0] pin_pu_strong, pin_in_en, pin_schmitt;
  logic [NPIN-1:0] key_low = 24'h000000;
  logic [1:0] ext_irq_pin_n, ext_irq_request, timer_toggle_en;
  logic [1:0] ext_irq_vector = 2'h0;
  logic [1:0] irq_low = 2'h0;
  logic port_reset_high_cfg = 1'b1;
  logic crystal_osc_sel = 1'b0;
  logic internal_reset_cfg = 1'b0;
  logic cpu_idle = 1'b0;
  logic cpu_power_down = 1'b0;
  logic keypad_irq_request, cpu_wake, clock_out_en;
  int errors = 0;
  int n_checks = 0;
  int cyc = 0;
  always #4 clk = ~clk;
  pkw_port_io i_dut (.clk, .reset_n, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata,
    .pin_in, .pin_pull_down, .pin_pu_very_weak, .pin_pu_weak, .pin_pu_strong, .pin_in_en,
    .pin_schmitt, .ext_irq_pin_n, .ext_irq_vector, .port_reset_high_cfg, .crystal_osc_sel,
    .internal_reset_cfg, .cpu_idle, .cpu_power_down, .ext_irq_request, .keypad_irq_request,
    .cpu_wake, .timer_toggle_en, .clock_out_en);
  pkw_pin_model i_model (.clk, .key_low, .irq_low, .pd(pin_pull_down),
    .pu(pin_pu_very_weak | pin_pu_strong), .pin_in, .ext_irq_pin_n);
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [NPIN-1:0] exp, input logic [NPIN-1:0] got);
    n_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
    #1;
    chk("reg_rdata", exp, reg_rdata);
  endtask : rd
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  // twelve clocks covers two machine-cycle samples
  task automatic irq(input logic [1:0] lv);
    irq_low <= lv;
    repeat (12) @(posedge clk);
  endtask : irq
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      errors++;
      close_out();
    end
  end
  initial
  begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    rd(ADDR_P0_LATCH, 8'hFF);
    rd(ADDR_P1_MODE_B, 8'h00);
    #1;
    chk("very_weak", 24'h03D3FF, pin_pu_very_weak);
    $display("test reset done");
    wr(ADDR_P0_LATCH, 8'hF0);
    for (int m = 3; m >= 0; m--)
    begin
      wr(ADDR_P0_MODE_A, {8{m[1]}});
      wr(ADDR_P0_MODE_B, {8{m[0]}});
      step(3);
      chk("pull_down", {16'h0, m == 2 ? 8'h00 : 8'h0F}, pin_pull_down);
      chk("strong", {16'h0, m == 1 ? 8'hF0 : 8'h00}, pin_pu_strong);
      if (m > 1)
        chk("p0 ups", 24'h0, (pin_pu_very_weak | pin_pu_weak) & 24'hFF);
    end
    chk("weak", 24'hF0, pin_pu_weak & 24'hFF);
    rd(ADDR_P0_PINS, 8'hF0);
    $display("test modes done");
    wr(ADDR_P0_LATCH, 8'hFF);
    #1;
    for (int i = 0; i < 3; i++)
    begin
      chk("strong pulse", i < 2 ? 24'hF : 24'h0, pin_pu_strong);
      step(1);
    end
    wr(ADDR_P1_LATCH, 8'h00);
    step(1);
    chk("p1 pd", 24'h00DF00, pin_pull_down);
    wr(ADDR_P1_LATCH, 8'hFF);
    $display("test strong and fixed done");
    crystal_osc_sel <= 1'b1;
    internal_reset_cfg <= 1'b1;
    wr(ADDR_P2_MODE_A, 8'hE0);
    step(1);
    chk("osc in_en", 24'h0, pin_in_en & 24'h030000);
    chk("rst in_en", 24'h1, pin_in_en[PIN_RST]);
    chk("toggles", 24'h7, {clock_out_en, timer_toggle_en});
    chk("schmitt", 24'h002C00, pin_schmitt);
    wr(ADDR_P2_MODE_A, 8'h1C);
    step(1);
    chk("schmitt on", 24'h00FFFF, pin_schmitt & 24'h00FFFF);
    $display("test config done");
    wr(ADDR_IRQ_EN, 8'h03);
    irq(2'h1);
    chk("level req", 24'h1, ext_irq_request);
    irq(2'h0);
    chk("level off", 24'h0, ext_irq_request);
    wr(ADDR_TIRQ_CTRL, 8'h0A);
    step(1);
    chk("level sw", 24'h0, ext_irq_request);
    wr(ADDR_TIRQ_CTRL, 8'h05);
    cpu_idle <= 1'b1;
    irq(2'h3);
    irq(2'h0);
    chk("edge req", 24'h3, ext_irq_request);
    chk("idle wake", 24'h1, cpu_wake);
    ext_irq_vector <= 2'h1;
    @(posedge clk);
    ext_irq_vector <= 2'h0;
    step(1);
    chk("vector clr", 24'h2, ext_irq_request);
    @(posedge clk);
    cpu_idle <= 1'b0;
    $display("test ext irq done");
    wr(ADDR_IRQ_EN, 8'h04);
    wr(ADDR_KEYPAD_EN, 8'h01);
    key_low <= 24'h2;
    step(3);
    chk("kb masked", 24'h0, keypad_irq_request);
    @(posedge clk);
    key_low <= 24'h1;
    cpu_power_down <= 1'b1;
    step(3);
    @(posedge clk);
    key_low <= 24'h0;
    step(3);
    chk("kb held", 24'h1, keypad_irq_request);
    chk("pd wake", 24'h1, cpu_wake);
    wr(ADDR_IRQ_EN, 8'h00);
    step(1);
    chk("kb gated", 24'h0, keypad_irq_request);
    rd(ADDR_AUX_CTRL, 8'h01);
    wr(ADDR_AUX_CTRL, 8'h00);
    rd(ADDR_AUX_CTRL, 8'h00);
    $display("test keypad done");
    close_out();
  end
endmodule : tb
